// ### design/input_synchronizer.sv
/*
  Two-stage synchroniser for a bank of asynchronous discrete inputs.
  Assumes the inputs are slow levels from contacts; no debounce is done here.
*/
`timescale 1ns/10ps
module input_synchronizer #(
  parameter int WIDTH = 7
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import servo_input_pkg::*;

  logic [WIDTH-1:0] meta_reg;

  // ----------------------------------------------------------------------------
  // Per-bit two-flop chain
  // ----------------------------------------------------------------------------
  // The first stage feeds only the second stage, so metastability stays contained.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always_ff @(posedge clock) begin
        if (rst) begin
          meta_reg[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule : input_synchronizer

// ### design/servo_drive_input_decoder.sv
/*
  Discrete-input decoder of a servo drive: enable, gain mode, overtravel, torque limit or jog, home slowdown.
  Assumes contact inputs arrive asynchronously and that speed reference and motor-stopped come from this clock.
*/
// Overview of operation
// [RULE1] Enable request puts the drive in a state that accepts motion references.
// [RULE2] Enable request releases the output-stage block and disengages dynamic braking.
// [RULE3] Input configuration bit 0 makes drive enable permanently present.
// [RULE4] Gain-mode function: gain select switches speed loop from PI to P-only.
// [RULE5] Configuration bit 2 sets jog function; gain select then picks preset jog speed.
// [RULE6] Limit switches hold prohibit inputs closed normally, open at the limit.
// [RULE7] Configuration bit 1 disables overtravel; other settings force either prohibit on.
// [RULE8] Configuration bit 2 makes torque limit inputs torque limits or jog run commands.
// [RULE9] Torque limit magnitudes and jog speeds come from stored constants.
// [RULE10] Origin return decelerates on home slowdown switch, closed when actuated by default.
// [RULE11] Configuration bit 4 inverts home slowdown switch sense.
// [RULE12] Host sets pulse configuration bit 3 before supplying pulse references.
// [RULE13] Host sets origin configuration bit 7 before using an external origin signal.
// [RULE14] Overtravel forces speed reference to zero, stops motor, then zero-clamps.
// [RULE15] Enable removed while turning stops the motor with the dynamic brake.
// [RULE16] Slowdown switch actuation during origin return drops speed to creep speed.
// [RULE17] Every discrete input passes two synchronising flip-flops before use.
`timescale 1ns/10ps
module servo_drive_input_decoder (
  input wire logic clock,
  input wire logic rst,
  input wire servo_input_pkg::control_inputs_t pins,
  input wire logic [servo_input_pkg::CFG_WIDTH-1:0] input_configuration_word,
  input wire logic [servo_input_pkg::CFG_WIDTH-1:0] pulse_configuration_word,
  input wire logic [servo_input_pkg::CFG_WIDTH-1:0] origin_configuration_word,
  input wire servo_input_pkg::drive_constants_t constants,
  input wire logic signed [servo_input_pkg::SPEED_WIDTH-1:0] speed_reference_in,
  input wire logic motor_stopped,
  input wire logic origin_return_request,
  output logic reference_ready,
  output logic output_stage_enable,
  output logic dynamic_brake_on,
  output logic speed_loop_p_only,
  output logic signed [servo_input_pkg::SPEED_WIDTH-1:0] speed_reference_out,
  output logic [servo_input_pkg::SPEED_WIDTH-1:0] forward_torque_limit_out,
  output logic [servo_input_pkg::SPEED_WIDTH-1:0] reverse_torque_limit_out,
  output logic overtravel_active,
  output logic zero_clamp,
  output logic origin_creep_speed,
  output logic pulse_reference_accept,
  output logic external_origin_select
);
  import servo_input_pkg::*;

  // ----------------------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------------------
  control_inputs_t sync_pins;

  input_synchronizer #(
    .WIDTH(INPUT_COUNT)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .async_in(pins),
    .sync_out(sync_pins)
  ); // see [RULE17]

  // ----------------------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------------------
  logic auto_enable;
  logic prohibit_off;
  logic jog_mode;
  logic slowdown_invert;
  logic enable_present;
  logic fwd_prohibit;
  logic rev_prohibit;
  logic slowdown_actuated;
  logic slowdown_prev_reg;
  logic slowdown_next;

  assign auto_enable = input_configuration_word[IN_CFG_AUTO_ENABLE_BIT];
  assign prohibit_off = input_configuration_word[IN_CFG_PROHIBIT_OFF_BIT];
  assign jog_mode = input_configuration_word[IN_CFG_JOG_MODE_BIT];
  assign slowdown_invert = input_configuration_word[IN_CFG_SLOWDOWN_INVERT_BIT];

  assign enable_present = sync_pins.drive_enable_request | auto_enable; // see [RULE3]

  // A prohibit input is active when its contact opens, so a broken wire also stops travel.
  assign fwd_prohibit = !prohibit_off &&
    (input_configuration_word[IN_CFG_ALWAYS_FWD_PROHIBIT_BIT] || !sync_pins.forward_travel_prohibit); // see [RULE7]
  assign rev_prohibit = !prohibit_off &&
    (input_configuration_word[IN_CFG_ALWAYS_REV_PROHIBIT_BIT] || !sync_pins.reverse_travel_prohibit); // see [RULE7]

  assign slowdown_actuated = sync_pins.home_slowdown_switch ^ slowdown_invert; // see [RULE10] see [RULE11]
  assign slowdown_next = slowdown_actuated;

  // ----------------------------------------------------------------------------
  // Drive enable state
  // ----------------------------------------------------------------------------
  drive_state_t drive_state_reg;
  drive_state_t drive_state_next;

  always_comb begin
    drive_state_next = drive_state_reg;
    unique case (drive_state_reg)
      DRIVE_OFF: begin
        if (enable_present) begin
          drive_state_next = DRIVE_ON; // see [RULE1]
        end
      end
      DRIVE_ON: begin
        if (!enable_present) begin
          drive_state_next = motor_stopped ? DRIVE_OFF : DRIVE_BRAKING; // see [RULE15]
        end
      end
      DRIVE_BRAKING: begin
        if (enable_present) begin
          drive_state_next = DRIVE_ON;
        end else if (motor_stopped) begin
          drive_state_next = DRIVE_OFF;
        end
      end
      default: begin
        drive_state_next = DRIVE_OFF;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      drive_state_reg <= DRIVE_OFF;
    end else begin
      drive_state_reg <= drive_state_next;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reference_ready <= 1'b0;
      output_stage_enable <= 1'b0;
      dynamic_brake_on <= 1'b1;
    end else begin
      reference_ready <= (drive_state_next == DRIVE_ON); // see [RULE1]
      output_stage_enable <= (drive_state_next == DRIVE_ON); // see [RULE2]
      dynamic_brake_on <= (drive_state_next != DRIVE_ON); // see [RULE2] see [RULE15]
    end
  end

  // ----------------------------------------------------------------------------
  // Gain mode, jog and torque limit selection
  // ----------------------------------------------------------------------------
  logic jog_forward;
  logic jog_reverse;
  logic [SPEED_WIDTH-1:0] jog_speed;
  logic signed [SPEED_WIDTH-1:0] command_speed;

  assign jog_forward = jog_mode && sync_pins.forward_torque_limit_input; // see [RULE8]
  assign jog_reverse = jog_mode && sync_pins.reverse_torque_limit_input; // see [RULE8]
  assign jog_speed = sync_pins.gain_mode_select ? constants.jog_speed_2 : constants.jog_speed_1; // see [RULE5] see [RULE9]

  // Both jog commands at once cancel each other rather than picking a direction.
  always_comb begin
    if (jog_forward && !jog_reverse) begin
      command_speed = jog_speed;
    end else if (jog_reverse && !jog_forward) begin
      command_speed = SPEED_ZERO - jog_speed;
    end else if (jog_mode) begin
      command_speed = SPEED_ZERO;
    end else begin
      command_speed = speed_reference_in;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      speed_loop_p_only <= 1'b0;
    end else begin
      speed_loop_p_only <= !jog_mode && sync_pins.gain_mode_select; // see [RULE4] see [RULE5]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      forward_torque_limit_out <= SPEED_ZERO;
      reverse_torque_limit_out <= SPEED_ZERO;
    end else begin
      forward_torque_limit_out <= (!jog_mode && sync_pins.forward_torque_limit_input) ?
        constants.forward_torque_limit : constants.torque_limit_max; // see [RULE8] see [RULE9]
      reverse_torque_limit_out <= (!jog_mode && sync_pins.reverse_torque_limit_input) ?
        constants.reverse_torque_limit : constants.torque_limit_max; // see [RULE8] see [RULE9]
    end
  end

  // ----------------------------------------------------------------------------
  // Overtravel and speed reference
  // ----------------------------------------------------------------------------
  logic overtravel;

  assign overtravel = fwd_prohibit || rev_prohibit;

  always_ff @(posedge clock) begin
    if (rst) begin
      speed_reference_out <= SPEED_ZERO;
      overtravel_active <= 1'b0;
      zero_clamp <= 1'b0;
    end else begin
      overtravel_active <= overtravel;
      // Overtravel overrides every command source, jog included.
      if (overtravel || drive_state_next != DRIVE_ON) begin
        speed_reference_out <= SPEED_ZERO; // see [RULE14]
      end else begin
        speed_reference_out <= command_speed;
      end
      zero_clamp <= overtravel && motor_stopped && (drive_state_next == DRIVE_ON); // see [RULE14]
    end
  end

  // ----------------------------------------------------------------------------
  // Origin return
  // ----------------------------------------------------------------------------
  home_state_t home_state_reg;
  home_state_t home_state_next;

  always_comb begin
    home_state_next = home_state_reg;
    unique case (home_state_reg)
      HOME_IDLE: begin
        if (origin_return_request && reference_ready) begin
          home_state_next = HOME_FAST;
        end
      end
      HOME_FAST: begin
        if (!origin_return_request || !reference_ready) begin
          home_state_next = HOME_IDLE;
        end else if (slowdown_actuated && !slowdown_prev_reg) begin
          home_state_next = HOME_CREEP; // see [RULE16] see [RULE10]
        end
      end
      HOME_CREEP: begin
        if (!origin_return_request || !reference_ready) begin
          home_state_next = HOME_IDLE;
        end
      end
      default: begin
        home_state_next = HOME_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      home_state_reg <= HOME_IDLE;
      slowdown_prev_reg <= 1'b0;
      origin_creep_speed <= 1'b0;
    end else begin
      home_state_reg <= home_state_next;
      slowdown_prev_reg <= slowdown_next;
      origin_creep_speed <= (home_state_next == HOME_CREEP); // see [RULE16]
    end
  end

  // ----------------------------------------------------------------------------
  // Host-set enables for pulse reference and external origin
  // ----------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      pulse_reference_accept <= 1'b0;
      external_origin_select <= 1'b0;
    end else begin
      pulse_reference_accept <= pulse_configuration_word[PULSE_CFG_ACCEPT_BIT]; // see [RULE12]
      external_origin_select <= origin_configuration_word[ORIGIN_CFG_EXTERNAL_BIT]; // see [RULE13]
    end
  end

endmodule : servo_drive_input_decoder

// ### pkg/servo_input_pkg.sv
/*
  Shared constants and carrier types for the servo drive discrete-input decoder.
  Assumes a single 100 MHz clock and that the configuration words are held stable by the drive firmware.
*/
package servo_input_pkg;

  // ----------------------------------------------------------------------------
  // Configuration word layouts
  // ----------------------------------------------------------------------------
  localparam int CFG_WIDTH = 8;
  localparam int IN_CFG_AUTO_ENABLE_BIT = 0;
  localparam int IN_CFG_PROHIBIT_OFF_BIT = 1;
  localparam int IN_CFG_JOG_MODE_BIT = 2;
  localparam int IN_CFG_SLOWDOWN_INVERT_BIT = 4;
  localparam int IN_CFG_ALWAYS_FWD_PROHIBIT_BIT = 5;
  localparam int IN_CFG_ALWAYS_REV_PROHIBIT_BIT = 6;
  localparam int PULSE_CFG_ACCEPT_BIT = 3;
  localparam int ORIGIN_CFG_EXTERNAL_BIT = 7;

  // ----------------------------------------------------------------------------
  // Data widths and reset values
  // ----------------------------------------------------------------------------
  localparam int SPEED_WIDTH = 16;
  localparam int SYNC_STAGES = 2;
  localparam int INPUT_COUNT = 7;
  localparam logic [SPEED_WIDTH-1:0] SPEED_ZERO = 16'h0000;
  localparam logic [INPUT_COUNT-1:0] INPUT_RESET = 7'h00;

  // Discrete inputs; a level of 1 means the contact is closed.
  typedef struct packed {
    logic drive_enable_request;
    logic gain_mode_select;
    logic forward_travel_prohibit;
    logic reverse_travel_prohibit;
    logic forward_torque_limit_input;
    logic reverse_torque_limit_input;
    logic home_slowdown_switch;
  } control_inputs_t;

  // Stored constants used by the decoder.
  typedef struct packed {
    logic [SPEED_WIDTH-1:0] jog_speed_1;
    logic [SPEED_WIDTH-1:0] jog_speed_2;
    logic [SPEED_WIDTH-1:0] forward_torque_limit;
    logic [SPEED_WIDTH-1:0] reverse_torque_limit;
    logic [SPEED_WIDTH-1:0] torque_limit_max;
  } drive_constants_t;

  typedef enum logic [2:0] {
    DRIVE_OFF = 3'b001,
    DRIVE_ON = 3'b010,
    DRIVE_BRAKING = 3'b100
  } drive_state_t;

  typedef enum logic [2:0] {
    HOME_IDLE = 3'b001,
    HOME_FAST = 3'b010,
    HOME_CREEP = 3'b100
  } home_state_t;

endpackage : servo_input_pkg

// ### test/limit_switch_model.sv
/* Model of the machine limit switches and the host's configuration words.
   Assumes the bench says when the axis sits at a limit and which host features are in use. */
`timescale 1ns/10ps
module limit_switch_model (
  input wire logic [1:0] at_limit,
  input wire logic use_pulse,
  input wire logic use_ext_origin,
  output logic fwd_closed,
  output logic rev_closed,
  output logic [7:0] pulse_cfg,
  output logic [7:0] origin_cfg
);
  // Contacts are closed in normal travel and open at the limit.
  assign fwd_closed = !at_limit[1];
  assign rev_closed = !at_limit[0];
  assign pulse_cfg = {4'h0, use_pulse, 3'h0};
  assign origin_cfg = {use_ext_origin, 7'h00};
endmodule : limit_switch_model

// ### test/servo_drive_input_decoder_props.sv
/* Assertion checker for the servo drive input decoder ports.
   Assumes the package is compiled first; bound to every decoder instance. */
`timescale 1ns/10ps
module servo_drive_input_decoder_props
  import servo_input_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire control_inputs_t pins,
  input wire logic [CFG_WIDTH-1:0] input_configuration_word,
  input wire drive_constants_t constants,
  input wire logic reference_ready,
  input wire logic output_stage_enable,
  input wire logic dynamic_brake_on,
  input wire logic speed_loop_p_only,
  input wire logic signed [SPEED_WIDTH-1:0] speed_reference_out,
  input wire logic [SPEED_WIDTH-1:0] forward_torque_limit_out,
  input wire logic overtravel_active,
  input wire logic zero_clamp,
  input wire logic origin_creep_speed
);
  // ----------------------------------------------------------------------------
  // Settling counter
  // ----------------------------------------------------------------------------
  // Pin checks look three edges back, so they wait until that history is all post-reset.
  logic [2:0] up_cnt;
  logic up_ok;
  always_ff @(posedge clock) begin
    if (rst) begin
      up_cnt <= 3'h0;
    end else if (up_cnt != 3'h5) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end
  assign up_ok = (up_cnt == 3'h5);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  AST_READY: assert property (up_ok && ($past(pins.drive_enable_request, 3) ||
    $past(input_configuration_word[0])) |-> reference_ready) else $error("ready not raised");
  AST_STAGE: assert property ((output_stage_enable == reference_ready) &&
    (dynamic_brake_on != reference_ready)) else $error("stage or brake mismatch");
  AST_PONLY: assert property (up_ok |-> speed_loop_p_only ==
    ($past(pins.gain_mode_select, 3) && !$past(input_configuration_word[2]))) else $error("gain mode wrong");
  AST_OT_SET: assert property (up_ok && !$past(input_configuration_word[1]) &&
    !$past(pins.forward_travel_prohibit, 3) |-> overtravel_active) else $error("overtravel missed");
  AST_OT_OFF: assert property ($past(input_configuration_word[1]) |-> !overtravel_active)
    else $error("overtravel not disabled");
  AST_OT_ZERO: assert property (overtravel_active |-> speed_reference_out == SPEED_ZERO)
    else $error("reference not zeroed");
  AST_CLAMP: assert property (zero_clamp |-> overtravel_active && reference_ready)
    else $error("clamp without cause");
  AST_TORQUE: assert property (up_ok && !$past(input_configuration_word[2]) &&
    $past(pins.forward_torque_limit_input, 3) |-> forward_torque_limit_out == $past(constants.forward_torque_limit))
    else $error("torque limit wrong");
  AST_CREEP: assert property (up_ok && $rose(origin_creep_speed) |->
    $past(pins.home_slowdown_switch, 3) != $past(input_configuration_word[4])) else $error("creep without switch");
endmodule : servo_drive_input_decoder_props

bind servo_drive_input_decoder servo_drive_input_decoder_props chk (.clock(clock), .rst(rst), .pins(pins),
  .input_configuration_word(input_configuration_word), .constants(constants), .reference_ready(reference_ready),
  .output_stage_enable(output_stage_enable), .dynamic_brake_on(dynamic_brake_on),
  .speed_loop_p_only(speed_loop_p_only), .speed_reference_out(speed_reference_out),
  .forward_torque_limit_out(forward_torque_limit_out), .overtravel_active(overtravel_active),
  .zero_clamp(zero_clamp), .origin_creep_speed(origin_creep_speed));

// ### test/servo_drive_input_decoder_tb_top.sv
/* Self-checking bench for the servo drive input decoder.
   Assumes the package, the design, the checker and the limit switch model are compiled first. */
`timescale 1ns/10ps
module servo_drive_input_decoder_tb_top;
  import servo_input_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b0, gm = 1'b0, fcl = 1'b0, rcl = 1'b0, slow = 1'b0, ms = 1'b1, orr = 1'b0;
  logic use_pulse = 1'b0, use_ext = 1'b0, fwd_ok, rev_ok;
  logic [1:0] at_lim = 2'h0;
  logic [CFG_WIDTH-1:0] in_cfg = 8'h00, pulse_cfg, origin_cfg;
  logic signed [SPEED_WIDTH-1:0] spd_in = 16'h0777, spd_out;
  logic ready, stage_on, brake, p_only, ot, clamp, creep, accept, ext_org;
  logic [SPEED_WIDTH-1:0] fwd_lim, rev_lim;
  drive_constants_t cst;
  control_inputs_t pins;
  int err_total = 0, compares = 0;
  assign cst = {16'h0123, 16'h0456, 16'h0200, 16'h0180, 16'h0300};
  assign pins = {en, gm, fwd_ok, rev_ok, fcl, rcl, slow};
  initial forever #5 clock = ~clock;
  limit_switch_model partner (.at_limit(at_lim), .use_pulse(use_pulse), .use_ext_origin(use_ext),
    .fwd_closed(fwd_ok), .rev_closed(rev_ok), .pulse_cfg(pulse_cfg), .origin_cfg(origin_cfg));
  servo_drive_input_decoder DUT (.clock(clock), .rst(rst), .pins(pins), .input_configuration_word(in_cfg),
    .pulse_configuration_word(pulse_cfg), .origin_configuration_word(origin_cfg), .constants(cst),
    .speed_reference_in(spd_in), .motor_stopped(ms), .origin_return_request(orr), .reference_ready(ready),
    .output_stage_enable(stage_on), .dynamic_brake_on(brake), .speed_loop_p_only(p_only),
    .speed_reference_out(spd_out), .forward_torque_limit_out(fwd_lim), .reverse_torque_limit_out(rev_lim),
    .overtravel_active(ot), .zero_clamp(clamp), .origin_creep_speed(creep), .pulse_reference_accept(accept),
    .external_origin_select(ext_org));
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : settle
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic chk16(input logic [SPEED_WIDTH-1:0] got, input logic [SPEED_WIDTH-1:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    settle(1);
    chk1(brake, 1'b1);
    chk1(accept, 1'b0);
    @(posedge clock);
    en <= 1'b1;
    settle(4);
    chk1(ready, 1'b1);
    chk1(stage_on, 1'b1);
    chk1(brake, 1'b0);
    chk16(spd_out, 16'h0777);
    @(posedge clock);
    gm <= 1'b1;
    fcl <= 1'b1;
    settle(4);
    chk1(p_only, 1'b1);
    chk16(fwd_lim, 16'h0200);
    chk16(rev_lim, 16'h0300);
    @(posedge clock);
    in_cfg <= 8'h04;
    settle(4);
    chk1(p_only, 1'b0);
    chk16(spd_out, 16'h0456);
    chk16(fwd_lim, 16'h0300);
    @(posedge clock);
    gm <= 1'b0;
    settle(4);
    chk16(spd_out, 16'h0123);
    @(posedge clock);
    rcl <= 1'b1;
    settle(4);
    chk16(spd_out, 16'h0000);
    @(posedge clock);
    fcl <= 1'b0;
    settle(4);
    chk16(spd_out, 16'hfedd);
    @(posedge clock);
    in_cfg <= 8'h00;
    settle(4);
    chk16(rev_lim, 16'h0180);
    @(posedge clock);
    rcl <= 1'b0;
    // Each limit in turn: stop, clamp, cancel, then force permanently.
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      at_lim <= i ? 2'h1 : 2'h2;
      ms <= 1'b0;
      settle(4);
      chk1(ot, 1'b1);
      chk16(spd_out, 16'h0000);
      chk1(clamp, 1'b0);
      @(posedge clock);
      ms <= 1'b1;
      settle(2);
      chk1(clamp, 1'b1);
      @(posedge clock);
      in_cfg <= 8'h02;
      settle(2);
      chk1(ot, 1'b0);
      @(posedge clock);
      at_lim <= 2'h0;
      in_cfg <= i ? 8'h40 : 8'h20;
      settle(4);
      chk1(ot, 1'b1);
      @(posedge clock);
      in_cfg <= 8'h00;
      settle(4);
    end
    @(posedge clock);
    ms <= 1'b0;
    en <= 1'b0;
    settle(4);
    chk1(ready, 1'b0);
    chk1(brake, 1'b1);
    @(posedge clock);
    ms <= 1'b1;
    settle(2);
    chk1(brake, 1'b1);
    chk1(stage_on, 1'b0);
    @(posedge clock);
    in_cfg <= 8'h01;
    settle(2);
    chk1(brake, 1'b0);
    chk1(ready, 1'b1);
    @(posedge clock);
    orr <= 1'b1;
    settle(2);
    chk1(creep, 1'b0);
    @(posedge clock);
    slow <= 1'b1;
    settle(4);
    chk1(creep, 1'b1);
    @(posedge clock);
    orr <= 1'b0;
    in_cfg <= 8'h11;
    settle(4);
    chk1(creep, 1'b0);
    @(posedge clock);
    orr <= 1'b1;
    settle(2);
    @(posedge clock);
    slow <= 1'b0;
    settle(4);
    chk1(creep, 1'b1);
    @(posedge clock);
    use_pulse <= 1'b1;
    use_ext <= 1'b1;
    settle(2);
    chk1(accept, 1'b1);
    chk1(ext_org, 1'b1);
    give_verdict();
  end
endmodule : servo_drive_input_decoder_tb_top
